// [src/latch_if.sv]
// Connection between the status word logic and one latching status bit
`timescale 1ns/1ps
interface latch_if;
    logic cond;
    logic clr;
    logic q;

    modport owner (input cond, input clr, output q);
    modport user  (output cond, output clr, input q);
endinterface : latch_if

// [src/mdc_edge.sv]
// Rising edge detector for the management clock pin
`timescale 1ns/1ps
module mdc_edge (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Sampled level and its rising edge
    input  wire logic level_in,
    output wire logic rise
);
    logic level_r;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level_in;
        end
    end

    assign rise = level_in & ~level_r;
endmodule : mdc_edge

// [src/phy_basic_status_register.sv]
// Basic status register of the PHY with its serial management frame slave
//
// Functional notes
// R1: Bit 15 always reads 0; four-pair 100 Mbps mode is absent.
// R2: Bits 14 to 11 always read 1 for the four TX and T abilities.
// R3: Bits 10 to 7 read 0; writes to this register are ignored.
// R4: Bit 6 reads 1; frames without preamble are accepted.
// R5: Bit 5 follows auto-negotiation completion, 0 after reset.
// R6: Bit 4 latches high on far-end fault until read or reset.
// R7: Far-end fault is raised by the partner ability fault flag.
// R8: Bit 3 always reads 1, auto-negotiation is possible.
// R9: Bit 2 shows a valid link at either speed, 0 after reset.
// R10: Link bit latches low on failure until the register is read.
// R11: Bit 1 latches high on jabber until read or reset.
// R12: Jabber is only taken while running at 10 Mbps.
// R13: Bit 0 always reads 1, extended registers exist.
// R14: A read returns latched values, then bits restart from live conditions.
`timescale 1ns/1ps
module phy_basic_status_register (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Management serial pins
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output wire logic        mdio_out,
    output wire logic        mdio_oe,
    // Station address of this PHY
    input  wire logic [4:0]  phy_addr,
    // Live conditions from the PHY core
    input  wire logic        autoneg_done,
    input  wire logic        link_ok,
    input  wire logic        far_end_fault_flag,
    input  wire logic        jabber_seen,
    input  wire logic        speed_100,
    // Observation of the register
    output wire logic [15:0] status_word,
    output wire logic        read_pulse
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_OPCODE,
        ST_ADDR,
        ST_TA_FLOAT,
        ST_TA_DRIVE,
        ST_RDATA,
        ST_DRAIN
    } frame_state_e;

    function automatic logic [15:0] build_status(input logic an_done,
                                                 input logic fault,
                                                 input logic link,
                                                 input logic jabber);
        logic [15:0] w;
        w = phy_status_pkg::STATUS_RESET;
        w[phy_status_pkg::POS_T4]           = 1'b0;    // R1
        w[phy_status_pkg::POS_TX_FD]        = 1'b1;    // R2
        w[phy_status_pkg::POS_TX_HD]        = 1'b1;    // R2
        w[phy_status_pkg::POS_10_FD]        = 1'b1;    // R2
        w[phy_status_pkg::POS_10_HD]        = 1'b1;    // R2
        w[phy_status_pkg::POS_PREAMBLE_SUP] = 1'b1;    // R4
        w[phy_status_pkg::POS_AN_DONE]      = an_done; // R5
        w[phy_status_pkg::POS_FAR_FAULT]    = fault;   // R6
        w[phy_status_pkg::POS_AN_ABLE]      = 1'b1;    // R8
        w[phy_status_pkg::POS_LINK]         = link;    // R9
        w[phy_status_pkg::POS_JABBER]       = jabber;  // R11
        w[phy_status_pkg::POS_EXTENDED]     = 1'b1;    // R13
        return w;
    endfunction : build_status

    function automatic logic frame_hits(input logic [9:0] addr,
                                        input logic [4:0] own_addr);
        return (addr[9:5] == own_addr) &&
               (addr[4:0] == phy_status_pkg::REG_BASIC_STATUS);
    endfunction : frame_hits

    frame_state_e state_r;
    frame_state_e state_nxt;
    logic [4:0]   cnt_r;
    logic [4:0]   cnt_nxt;
    logic [1:0]   op_r;
    logic [1:0]   op_nxt;
    logic [9:0]   addr_r;
    logic [9:0]   addr_nxt;
    logic [15:0]  shift_r;
    logic [15:0]  shift_nxt;
    logic         mdio_out_r;
    logic         mdio_out_nxt;
    logic         mdio_oe_r;
    logic         mdio_oe_nxt;
    logic         an_done_r;
    logic [15:0]  status_word_r;
    logic         read_pulse_r;
    logic         read_clear;
    logic         mdc_rise;

    // Shift registers as seen with the bit now on the pin
    wire  [1:0]   op_full    = {op_r[0], mdio_in};
    wire  [9:0]   addr_full  = {addr_r[8:0], mdio_in};
    wire          op_known   = (op_full == phy_status_pkg::OP_READ) ||
                               (op_full == phy_status_pkg::OP_WRITE);
    wire          read_hit   = (op_r == phy_status_pkg::OP_READ) &&
                               frame_hits(addr_full, phy_addr);
    wire          jabber_10m = jabber_seen & ~speed_100; // R12
    // Counter end points of each frame field
    wire          op_end     = (cnt_r == phy_status_pkg::OP_LAST);
    wire          addr_end   = (cnt_r == phy_status_pkg::ADDR_LAST);
    wire          data_end   = (cnt_r == phy_status_pkg::DATA_LAST);
    wire          drain_end  = (cnt_r == phy_status_pkg::DRAIN_LAST);
    wire  [4:0]   cnt_step   = cnt_r + 5'h01;

    // One carrier per latching bit; the same read clears all three
    latch_if fault_lat ();
    latch_if link_lat ();
    latch_if jabber_lat ();

    assign fault_lat.cond  = far_end_fault_flag; // R7
    assign fault_lat.clr   = read_clear;
    assign link_lat.cond   = link_ok;
    assign link_lat.clr    = read_clear;
    assign jabber_lat.cond = jabber_10m;
    assign jabber_lat.clr  = read_clear;

    // Built from held latch values, so a read returns them before its clear
    wire [15:0] live_word = build_status(an_done_r, fault_lat.q, link_lat.q, jabber_lat.q);

    // Management clock edges are found in the system clock domain
    mdc_edge u_mdc_edge (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .level_in (mdc),
        .rise     (mdc_rise)
    );

    status_latch #(.LATCH_HIGH(1'b1)) u_fault_latch ( // R6
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .lat     (fault_lat.owner)
    );

    status_latch #(.LATCH_HIGH(1'b0)) u_link_latch ( // R10
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .lat     (link_lat.owner)
    );

    status_latch #(.LATCH_HIGH(1'b1)) u_jabber_latch ( // R11
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .lat     (jabber_lat.owner)
    );

    // Frame decoder, advanced once per management clock rising edge
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        op_nxt       = op_r;
        addr_nxt     = addr_r;
        shift_nxt    = shift_r;
        mdio_out_nxt = mdio_out_r;
        mdio_oe_nxt  = mdio_oe_r;
        read_clear   = 1'b0;
        if (mdc_rise) begin
            case (state_r)
                ST_IDLE: begin
                    mdio_oe_nxt = 1'b0;
                    // Any number of ones, even none, may precede the start bits
                    if (!mdio_in) begin // R4
                        state_nxt = ST_START;
                    end
                end
                ST_START: begin
                    // Second start bit must be a one
                    cnt_nxt   = phy_status_pkg::CNT_ZERO;
                    state_nxt = mdio_in ? ST_OPCODE : ST_IDLE;
                end
                ST_OPCODE: begin
                    op_nxt = op_full;
                    if (op_end) begin
                        cnt_nxt   = phy_status_pkg::CNT_ZERO;
                        // Opcodes other than read and write drop the frame
                        state_nxt = op_known ? ST_ADDR : ST_IDLE;
                    end else begin
                        cnt_nxt = cnt_step;
                    end
                end
                ST_ADDR: begin
                    addr_nxt = addr_full;
                    if (addr_end) begin
                        cnt_nxt = phy_status_pkg::CNT_ZERO;
                        // Writes and frames for others pass without effect
                        state_nxt = read_hit ? ST_TA_FLOAT : ST_DRAIN; // R3
                    end else begin
                        cnt_nxt = cnt_step;
                    end
                end
                ST_TA_FLOAT: begin
                    // Second turnaround bit is driven low by this block
                    mdio_oe_nxt  = 1'b1;
                    mdio_out_nxt = 1'b0;
                    state_nxt    = ST_TA_DRIVE;
                end
                ST_TA_DRIVE: begin
                    // Send the held values; latches restart from live state
                    read_clear   = 1'b1; // R14
                    mdio_out_nxt = live_word[15];
                    shift_nxt    = {live_word[14:0], 1'b0};
                    cnt_nxt      = phy_status_pkg::CNT_ZERO;
                    state_nxt    = ST_RDATA;
                end
                ST_RDATA: begin
                    if (data_end) begin
                        // Bus is let go after the last data bit
                        mdio_oe_nxt  = 1'b0;
                        mdio_out_nxt = 1'b0;
                        state_nxt    = ST_IDLE;
                    end else begin
                        mdio_out_nxt = shift_r[15];
                        shift_nxt    = {shift_r[14:0], 1'b0};
                        cnt_nxt      = cnt_step;
                    end
                end
                ST_DRAIN: begin
                    // Turnaround and data bits of frames not answered here
                    if (drain_end) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        cnt_nxt = cnt_step;
                    end
                end
                default: begin
                    mdio_oe_nxt = 1'b0;
                    state_nxt   = ST_IDLE;
                end
            endcase
        end
    end

    // Frame position
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= phy_status_pkg::CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Received frame header
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            op_r   <= 2'h0;
            addr_r <= 10'h000;
        end else begin
            op_r   <= op_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Outgoing data bits
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            shift_r <= phy_status_pkg::STATUS_RESET;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // Data pin drive
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mdio_out_r <= 1'b0;
            mdio_oe_r  <= 1'b0;
        end else begin
            mdio_out_r <= mdio_out_nxt;
            mdio_oe_r  <= mdio_oe_nxt;
        end
    end

    // Auto-negotiation state taken into the clock domain
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            an_done_r <= phy_status_pkg::AN_DONE_RESET;
        end else begin
            an_done_r <= autoneg_done; // R5
        end
    end

    // Register view and read strobe
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            status_word_r <= phy_status_pkg::STATUS_RESET;
            read_pulse_r  <= 1'b0;
        end else begin
            status_word_r <= live_word;
            read_pulse_r  <= read_clear;
        end
    end

    assign mdio_out    = mdio_out_r;
    assign mdio_oe     = mdio_oe_r;
    assign status_word = status_word_r;
    assign read_pulse  = read_pulse_r;
endmodule : phy_basic_status_register

// [src/phy_status_pkg.sv]
// Constants shared by the basic status register design
package phy_status_pkg;
    // Register map
    localparam logic [4:0]  REG_BASIC_STATUS = 5'h01;
    // Bit positions in the basic status word
    localparam int          POS_T4           = 15;
    localparam int          POS_TX_FD        = 14;
    localparam int          POS_TX_HD        = 13;
    localparam int          POS_10_FD        = 12;
    localparam int          POS_10_HD        = 11;
    localparam int          POS_PREAMBLE_SUP = 6;
    localparam int          POS_AN_DONE      = 5;
    localparam int          POS_FAR_FAULT    = 4;
    localparam int          POS_AN_ABLE      = 3;
    localparam int          POS_LINK         = 2;
    localparam int          POS_JABBER       = 1;
    localparam int          POS_EXTENDED     = 0;
    // Values after reset
    localparam logic        AN_DONE_RESET    = 1'b0;
    localparam logic        LATCH_RESET      = 1'b0;
    localparam logic [15:0] STATUS_RESET     = 16'h0000;
    // Management frame fields
    localparam logic [1:0]  OP_READ          = 2'h2;
    localparam logic [1:0]  OP_WRITE         = 2'h1;
    localparam logic [4:0]  CNT_ZERO         = 5'h00;
    localparam logic [4:0]  OP_LAST          = 5'h01;
    localparam logic [4:0]  ADDR_LAST        = 5'h09;
    localparam logic [4:0]  DATA_LAST        = 5'h0F;
    localparam logic [4:0]  DRAIN_LAST       = 5'h11;
endpackage : phy_status_pkg

// [src/status_latch.sv]
// One latching status bit, latching high or latching low
`timescale 1ns/1ps
module status_latch #(
    parameter logic LATCH_HIGH = 1'b1
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Condition, clear-on-read and held value
    latch_if.owner    lat
);
    logic q_r;
    logic q_nxt;

    // On the clearing read the bit restarts from the live condition
    assign q_nxt = LATCH_HIGH ? (lat.cond | (q_r & ~lat.clr))
                              : (lat.cond & (q_r | lat.clr));
    assign lat.q = q_r;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            q_r <= phy_status_pkg::LATCH_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule : status_latch

// [testbench/mdio_station.sv]
// Station manager model issuing management frames to the PHY
`timescale 1ns/1ps
module mdio_station (
    // Clock
    input  wire logic clk_sys,
    // Management pins
    input  wire logic mdio_out,
    input  wire logic mdio_oe,
    output wire logic mdc,
    output wire logic mdio_line
);
    logic mdc_r     = 1'h0;
    logic drv_en_r  = 1'h0;
    logic drv_bit_r = 1'h0;

    // Released line floats up through the pull-up
    assign mdio_line = mdio_oe ? mdio_out : (drv_en_r ? drv_bit_r : 1'h1);
    assign mdc       = mdc_r;

    // Four system clocks per bit, data changes with mdc low, sampled before the rise
    task automatic clk_bit(input logic en, input logic b, output logic s);
        @(posedge clk_sys);
        mdc_r     <= 1'h0;
        drv_en_r  <= en;
        drv_bit_r <= b;
        @(posedge clk_sys);
        @(negedge clk_sys);
        s = mdio_line;
        @(posedge clk_sys);
        mdc_r <= 1'h1;
        @(posedge clk_sys);
    endtask : clk_bit

    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, input int pre, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        wr;
        logic        s;
        hdr = {2'h1, op, pa, ra};
        wr  = (op == phy_status_pkg::OP_WRITE);
        repeat (pre) clk_bit(1'h1, 1'h1, s);
        for (int i = 13; i >= 0; i--) clk_bit(1'h1, hdr[i], s);
        clk_bit(wr, 1'h1, s);
        clk_bit(wr, 1'h0, s);
        for (int i = 15; i >= 0; i--) begin
            clk_bit(wr, wd[i], s);
            rd[i] = s;
        end
        @(posedge clk_sys);
        mdc_r    <= 1'h0;
        drv_en_r <= 1'h0;
    endtask : xfer
endmodule : mdio_station

// [testbench/phy_status_properties.sv]
// Concurrent checks on the basic status register ports
`timescale 1ns/1ps
module phy_status_properties (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Live conditions
    input wire logic        autoneg_done,
    input wire logic        link_ok,
    input wire logic        far_end_fault_flag,
    input wire logic        jabber_seen,
    input wire logic        speed_100,
    // Register view
    input wire logic [15:0] status_word,
    input wire logic        read_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_fixed_bits: assert property (
        $past(reset_n) |-> (status_word & 16'hFFC9) == 16'h7849)
        else $error("fixed status bits wrong");
    chk_an_follow: assert property (
        (reset_n && $stable(autoneg_done)) [*3] |=> status_word[5] == $past(autoneg_done))
        else $error("autoneg bit does not follow input");
    chk_link_fail: assert property (
        !link_ok |-> ##2 !status_word[2])
        else $error("link bit not cleared on failure");
    chk_link_rise: assert property (
        $rose(status_word[2]) |-> $past(read_pulse))
        else $error("link bit set without a read");
    chk_fault_set: assert property (
        far_end_fault_flag |-> ##2 status_word[4])
        else $error("fault bit not latched");
    chk_latch_hold: assert property (
        $fell(status_word[4]) || $fell(status_word[1]) |-> $past(read_pulse))
        else $error("latched bit dropped without a read");
    chk_jabber_set: assert property (
        jabber_seen && !speed_100 |-> ##2 status_word[1])
        else $error("jabber bit not latched");
    chk_jabber_fast: assert property (
        $rose(status_word[1]) |-> $past(jabber_seen && !speed_100, 2))
        else $error("jabber bit set without 10M jabber");
endmodule : phy_status_properties

// [testbench/testbench.sv]
// Self-checking bench reading the basic status register through frames
`timescale 1ns/1ps
module testbench;
    logic        clk_sys            = 1'h0;
    logic        reset_n            = 1'h0;
    logic        autoneg_done       = 1'h0;
    logic        link_ok            = 1'h1;
    logic        far_end_fault_flag = 1'h0;
    logic        jabber_seen        = 1'h0;
    logic        speed_100          = 1'h1;
    logic [4:0]  phy_addr           = 5'h03;
    logic        mdc;
    logic        mdio_line;
    logic        mdio_out;
    logic        mdio_oe;
    logic [15:0] status_word;
    logic [15:0] rd;
    int          num_errors         = 0;
    int          comparisons        = 0;
    int          cycles             = 0;
    int          oe_cycles          = 0;
    int          oe_before;

    always #20 clk_sys = ~clk_sys;

    phy_basic_status_register dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr),
        .autoneg_done(autoneg_done), .link_ok(link_ok),
        .far_end_fault_flag(far_end_fault_flag), .jabber_seen(jabber_seen),
        .speed_100(speed_100), .status_word(status_word), .read_pulse()
    );

    mdio_station station_u (
        .clk_sys(clk_sys), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .mdc(mdc), .mdio_line(mdio_line)
    );

    task automatic test_done();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic read_check(input int pre, input logic [15:0] exp);
        station_u.xfer(phy_status_pkg::OP_READ, phy_addr, phy_status_pkg::REG_BASIC_STATUS,
                       16'h0000, pre, rd);
        check("status read", rd, exp);
    endtask : read_check

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : hold

    always @(posedge clk_sys) begin
        cycles++;
        if (mdio_oe === 1'h1)
            oe_cycles++;
        if (cycles == 10000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        hold(3);
        reset_n <= 1'h1;
        read_check(0, 16'h7849);
        read_check(8, 16'h784D);
        autoneg_done <= 1'h1;
        link_ok      <= 1'h0;
        hold(3);
        link_ok <= 1'h1;
        hold(3);
        read_check(0, 16'h7869);
        read_check(0, 16'h786D);
        far_end_fault_flag <= 1'h1;
        jabber_seen        <= 1'h1;
        hold(3);
        read_check(0, 16'h787D);
        read_check(0, 16'h787D);
        far_end_fault_flag <= 1'h0;
        jabber_seen        <= 1'h0;
        hold(3);
        read_check(0, 16'h787D);
        read_check(0, 16'h786D);
        speed_100   <= 1'h0;
        jabber_seen <= 1'h1;
        hold(3);
        jabber_seen <= 1'h0;
        hold(3);
        read_check(0, 16'h786F);
        read_check(0, 16'h786D);
        oe_before = oe_cycles;
        station_u.xfer(phy_status_pkg::OP_WRITE, phy_addr, phy_status_pkg::REG_BASIC_STATUS,
                       16'hFFFF, 0, rd);
        check("drive cycles", oe_cycles[15:0], oe_before[15:0]);
        read_check(0, 16'h786D);
        autoneg_done       <= 1'h0;
        far_end_fault_flag <= 1'h1;
        hold(3);
        reset_n <= 1'h0;
        far_end_fault_flag <= 1'h0;
        hold(3);
        reset_n <= 1'h1;
        read_check(0, 16'h7849);
        test_done();
    end
endmodule : testbench

bind phy_basic_status_register phy_status_properties chk_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .autoneg_done(autoneg_done), .link_ok(link_ok),
    .far_end_fault_flag(far_end_fault_flag), .jabber_seen(jabber_seen),
    .speed_100(speed_100), .status_word(status_word), .read_pulse(read_pulse)
);
